// *** hw/bridge_primary_status.v ***
`include "bridge_status_defines.vh"
`default_nettype none

// Contract
// - 16-bit status word, resets to 0010h
// - Detected poison bit 15 always zero
// - Bit 14 set on enabled system error
// - Write one clears flag; zero keeps it
// - Bit 13 set on unsupported-request completion
// - Bit 12 set on completer-abort completion
// - Bit 11 reads zero
// - Bits 10:9, 7, 5 read zero
// - Bit 8 set on poisoned completion/write
// - Bit 8 sets only with parity response
// - Bit 4 reads one
// - Bit 3 follows internal legacy interrupt pending
// - Bit 3 ignores interrupt disable setting
// - Command bit 6 gates parity error action
// - Command bit 8 gates error messages
module bridge_primary_status (
    input wire ref_clk,
    input wire srst,
    input wire [11:0] cfg_addr,
    input wire [1:0] cfg_be,
    input wire cfg_wr_en,
    input wire [15:0] cfg_wdata,
    input wire cfg_rd_en,
    output reg [15:0] cfg_rdata_q,
    output reg cfg_rd_valid_q,
    input wire parity_response_enable,
    input wire error_messaging_enable,
    input wire intx_disable,
    input wire fatal_err_evt,
    input wire nonfatal_err_evt,
    input wire ur_cpl_evt,
    input wire ca_cpl_evt,
    input wire poisoned_cpl_evt,
    input wire poisoned_wr_evt,
    input wire intx_pending,
    output reg system_error_msg_q,
    output reg parity_error_action_q,
    output reg intx_assert_q
);

    // Flag index order inside the generate loop
    localparam [1:0] IDX_SSE = 2'd0;
    localparam [1:0] IDX_UR = 2'd1;
    localparam [1:0] IDX_CA = 2'd2;
    localparam [1:0] IDX_MDP = 2'd3;
    // Sized copy of the word address for the decode
    localparam [11:0] STATUS_WORD_ADDR = `STATUS_OFFSET;

    // Error flag bank
    wire [`ERR_FLAG_COUNT-1:0] flag_set;
    wire [`ERR_FLAG_COUNT-1:0] flag_clr;
    wire [`ERR_FLAG_COUNT-1:0] flag_q;
    wire [`ERR_FLAG_COUNT-1:0] flag_wbit;

    // Configuration access decode
    wire hit_wr;
    wire hit_rd;

    // Merged event sources
    wire err_evt;
    wire poison_evt;

    // Read image and registered outputs, with their next values
    reg [15:0] status_word;
    reg [15:0] cfg_rdata_d;
    reg cfg_rd_valid_d;
    reg intx_status_q;
    reg intx_status_d;
    reg intx_assert_d;
    reg system_error_msg_d;
    reg parity_error_action_d;
    integer fi;

    // Word decode shared by read and write paths; both byte addresses of the word hit
    function addr_hit;
        input [11:0] addr;
        begin
            addr_hit = (addr[11:1] == STATUS_WORD_ADDR[11:1]);
        end
    endfunction

    // Flag index to status bit position, shared by the clear path and the read image
    function [3:0] flag_pos;
        input integer idx;
        begin
            case (idx)
                IDX_SSE: flag_pos = 4'd`SYSTEM_ERROR_BIT;
                IDX_UR: flag_pos = 4'd`UNSUPPORTED_CPL_BIT;
                IDX_CA: flag_pos = 4'd`COMPLETER_ABORT_RX_BIT;
                IDX_MDP: flag_pos = 4'd`MASTER_POISON_BIT;
                default: flag_pos = 4'd`MASTER_POISON_BIT;
            endcase
        end
    endfunction

    // Byte enable that covers a given status bit
    function lane_en;
        input [1:0] be;
        input [3:0] pos;
        begin
            // Bits 15:8 ride on the upper enable, bits 7:0 on the lower
            lane_en = be[pos[3]];
        end
    endfunction

    // Access strobes qualified by the word decode
    assign hit_wr = cfg_wr_en & addr_hit(cfg_addr);
    assign hit_rd = cfg_rd_en & addr_hit(cfg_addr);

    // Either error severity counts; the message path does not tell them apart
    assign err_evt = fatal_err_evt | nonfatal_err_evt;
    assign poison_evt = poisoned_cpl_evt | poisoned_wr_evt;

    // System error and poison reach their sticky bits only when enabled; UR and CA completions always set theirs
    assign flag_set[IDX_SSE] = err_evt & error_messaging_enable;
    assign flag_set[IDX_UR] = ur_cpl_evt;
    assign flag_set[IDX_CA] = ca_cpl_evt;
    assign flag_set[IDX_MDP] = poison_evt & parity_response_enable;

    // One sticky cell per clearable flag; a set wins over a same-cycle clear
    genvar gi;
    generate
        for (gi = 0; gi < `ERR_FLAG_COUNT; gi = gi + 1) begin : g_flag
            assign flag_wbit[gi] = cfg_wdata[flag_pos(gi)];
            // Writes only clear when the lane holding the bit is enabled
            assign flag_clr[gi] = hit_wr & lane_en(cfg_be, flag_pos(gi)) & flag_wbit[gi];
            sticky_clear_flag u_flag (
                .ref_clk(ref_clk),
                .srst(srst),
                .set_evt(flag_set[gi]),
                .clr_req(flag_clr[gi]),
                .flag_q(flag_q[gi])
            );
        end
    endgenerate

    // Read image: fixed fields first, then the live flags dropped into place
    always @* begin
        status_word = 16'h0000;
        // Poisoned traffic is never reflected here since downstream parity is unchecked
        status_word[`DETECTED_POISON_BIT] = `DETECTED_POISON_VALUE;
        status_word[`COMPLETER_ABORT_TX_BIT] = `COMPLETER_ABORT_TX_VALUE;
        status_word[`SELECT_TIMING_HI:`SELECT_TIMING_LO] = `SELECT_TIMING_VALUE;
        status_word[`BACK_TO_BACK_BIT] = `BACK_TO_BACK_VALUE;
        status_word[`RESERVED_BIT6] = 1'b0;
        status_word[`FAST_66_BIT] = `FAST_66_VALUE;
        status_word[`CAP_LIST_BIT] = `CAP_LIST_VALUE;
        status_word[`INTX_STATUS_BIT] = intx_status_q;
        // Clearable flags land at their own positions
        for (fi = 0; fi < `ERR_FLAG_COUNT; fi = fi + 1) begin
            status_word[flag_pos(fi)] = flag_q[fi];
        end
    end

    // Unmapped reads answer zero so software never sees stale data
    always @* begin
        cfg_rdata_d = 16'h0000;
        if (hit_rd) begin
            cfg_rdata_d = status_word;
        end
    end

    // Every read strobe is answered, mapped or not, so the requester never waits
    always @* begin
        cfg_rd_valid_d = cfg_rd_en;
    end

    // Status tracks pending regardless of the disable; only the pin is gated
    always @* begin
        intx_status_d = intx_pending;
        intx_assert_d = intx_pending & ~intx_disable;
    end

    // Messages follow the command enables; the sticky bits are logged separately
    always @* begin
        system_error_msg_d = err_evt & error_messaging_enable;
        parity_error_action_d = poison_evt & parity_response_enable;
    end

    // Read port registers
    always @(posedge ref_clk) begin
        if (srst) begin
            cfg_rdata_q <= 16'h0000;
            cfg_rd_valid_q <= 1'b0;
        end else begin
            cfg_rdata_q <= cfg_rdata_d;
            cfg_rd_valid_q <= cfg_rd_valid_d;
        end
    end

    // Interrupt registers; reset clears the pending copy so the word reads its default
    always @(posedge ref_clk) begin
        if (srst) begin
            intx_status_q <= 1'b0;
            intx_assert_q <= 1'b0;
        end else begin
            intx_status_q <= intx_status_d;
            intx_assert_q <= intx_assert_d;
        end
    end

    // Error message registers
    always @(posedge ref_clk) begin
        if (srst) begin
            system_error_msg_q <= 1'b0;
            parity_error_action_q <= 1'b0;
        end else begin
            system_error_msg_q <= system_error_msg_d;
            parity_error_action_q <= parity_error_action_d;
        end
    end

endmodule

`default_nettype wire

// *** hw/bridge_status_defines.vh ***
`ifndef BRIDGE_STATUS_DEFINES_VH
`define BRIDGE_STATUS_DEFINES_VH

// Configuration byte address of the primary status word
`define STATUS_OFFSET 12'h006
`define STATUS_RESET 16'h0010

// Field positions
`define DETECTED_POISON_BIT 15
`define SYSTEM_ERROR_BIT 14
`define UNSUPPORTED_CPL_BIT 13
`define COMPLETER_ABORT_RX_BIT 12
`define COMPLETER_ABORT_TX_BIT 11
`define SELECT_TIMING_HI 10
`define SELECT_TIMING_LO 9
`define MASTER_POISON_BIT 8
`define BACK_TO_BACK_BIT 7
`define RESERVED_BIT6 6
`define FAST_66_BIT 5
`define CAP_LIST_BIT 4
`define INTX_STATUS_BIT 3

// Fixed read-only values
`define DETECTED_POISON_VALUE 1'b0
`define COMPLETER_ABORT_TX_VALUE 1'b0
`define SELECT_TIMING_VALUE 2'b00
`define BACK_TO_BACK_VALUE 1'b0
`define FAST_66_VALUE 1'b0
`define CAP_LIST_VALUE 1'b1

// Number of write-one-to-clear error flags
`define ERR_FLAG_COUNT 4

`endif

// *** hw/sticky_clear_flag.v ***
`default_nettype none

module sticky_clear_flag (
    input wire ref_clk,
    input wire srst,
    input wire set_evt,
    input wire clr_req,
    output reg flag_q
);

    reg flag_d;

    always @* begin
        flag_d = flag_q;
        if (clr_req) begin
            flag_d = 1'b0;
        end
        // A set in the clearing cycle still lands, so no event is lost
        if (set_evt) begin
            flag_d = 1'b1;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule

`default_nettype wire

// *** test/cpl_source.sv ***
`default_nettype none
module cpl_source (
    input wire logic fire,
    input wire logic [1:0] sts,
    output logic ur_cpl_evt,
    output logic ca_cpl_evt,
    output logic poisoned_cpl_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // Code 0 is a clean completion and raises nothing
    assign ur_cpl_evt = fire && sts == 2'h1;
    assign ca_cpl_evt = fire && sts == 2'h2;
    assign poisoned_cpl_evt = fire && sts == 2'h3;
endmodule
`default_nettype wire

// *** test/bridge_status_properties.sv ***
`default_nettype none
module bridge_status_properties (
    input wire logic ref_clk, srst, cfg_wr_en, cfg_rd_en, cfg_rd_valid_q, error_messaging_enable,
    input wire logic fatal_err_evt, nonfatal_err_evt, ur_cpl_evt, ca_cpl_evt, system_error_msg_q,
    input wire logic [11:0] cfg_addr,
    input wire logic [1:0] cfg_be,
    input wire logic [15:0] cfg_wdata, cfg_rdata_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire hit = cfg_addr[11:1] == 11'h003;
    sequence s_ur; ur_cpl_evt ##1 cfg_rd_en && hit; endsequence
    sequence s_ca; ca_cpl_evt ##1 cfg_rd_en && hit; endsequence
    sequence s_clr; cfg_wr_en && cfg_be[1] && cfg_wdata[13] && hit && !ur_cpl_evt ##1 cfg_rd_en && hit; endsequence
    property p_rv; cfg_rd_en |=> cfg_rd_valid_q; endproperty
    a_rv: assert property (p_rv) else $error("read unanswered");
    property p_idle; !cfg_rd_en |=> cfg_rdata_q == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("data without read");
    property p_zero; (cfg_rdata_q & 16'h8ee7) == 16'h0000; endproperty
    a_zero: assert property (p_zero) else $error("fixed bit set");
    property p_cap; cfg_rd_en && hit |=> cfg_rdata_q[4]; endproperty
    a_cap: assert property (p_cap) else $error("cap flag low");
    property p_ur; s_ur |=> cfg_rdata_q[13]; endproperty
    a_ur: assert property (p_ur) else $error("ur flag low");
    property p_ca; s_ca |=> cfg_rdata_q[12]; endproperty
    a_ca: assert property (p_ca) else $error("ca flag low");
    property p_clr; s_clr |=> !cfg_rdata_q[13]; endproperty
    a_clr: assert property (p_clr) else $error("flag kept");
    property p_serr; (fatal_err_evt || nonfatal_err_evt) && error_messaging_enable |=> system_error_msg_q; endproperty
    a_serr: assert property (p_serr) else $error("no error message");
endmodule
bind bridge_primary_status bridge_status_properties chk (.*);
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, srst = 1, cfg_wr_en = 0, cfg_rd_en = 0, fire = 0, fatal_err_evt = 0, nonfatal_err_evt = 0;
    logic poisoned_wr_evt = 0, parity_response_enable = 0, error_messaging_enable = 0, intx_disable = 0;
    logic intx_pending = 0;
    logic [11:0] cfg_addr = 12'h006;
    logic [1:0] cfg_be = 2'h0, sts = 2'h0;
    logic [15:0] cfg_wdata = 16'h0000, st = 16'h0000;
    logic [2:0] side = 3'h0;
    wire ur_cpl_evt, ca_cpl_evt, poisoned_cpl_evt, cfg_rd_valid_q, system_error_msg_q, parity_error_action_q;
    wire intx_assert_q;
    wire [15:0] cfg_rdata_q;
    int failures = 0, total_checks = 0;
    bridge_primary_status uut (.*);
    cpl_source dn (.*);
    initial forever #10 ref_clk = ~ref_clk;
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return s | {1'b0, (fatal_err_evt | nonfatal_err_evt) & error_messaging_enable, ur_cpl_evt, ca_cpl_evt,
            3'h0, (poisoned_cpl_evt | poisoned_wr_evt) & parity_response_enable, 8'h00};
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // The answer stands for one cycle after the read edge, so it is looked at on the next falling edge
    task automatic rdchk;
        cfg_rd_en = 1;
        @(negedge ref_clk);
        cfg_rd_en = 0;
        check(cfg_rd_valid_q ? cfg_rdata_q : 16'hxxxx,
            cfg_addr[11:1] == 11'h003 ? st | {12'h001, intx_pending, 3'h0} : 16'h0);
    endtask
    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'ha0fe));
        repeat (6) @(negedge ref_clk);
        srst = 0;
        rdchk;
        $display("reset test done");
        // Event and clearing write in one cycle: the set must win
        {fire, sts, cfg_be, cfg_wdata, cfg_wr_en} = {1'b1, 2'h1, 2'h2, 16'h2000, 1'b1};
        @(negedge ref_clk);
        st = nxt(st);
        {fire, cfg_wr_en} = 2'h0;
        rdchk;
        cfg_wr_en = 1;
        @(negedge ref_clk);
        cfg_wr_en = 0;
        st &= ~16'h2000;
        rdchk;
        $display("corner test done");
        repeat (400) begin
            {fatal_err_evt, nonfatal_err_evt, poisoned_wr_evt, fire, sts, parity_response_enable,
                error_messaging_enable, intx_disable, intx_pending} = 10'($urandom);
            @(negedge ref_clk);
            st = nxt(st);
            side = {(fatal_err_evt | nonfatal_err_evt) & error_messaging_enable,
                (poisoned_cpl_evt | poisoned_wr_evt) & parity_response_enable, intx_pending & ~intx_disable};
            check({13'h0, system_error_msg_q, parity_error_action_q, intx_assert_q}, {13'h0, side});
            {fatal_err_evt, nonfatal_err_evt, poisoned_wr_evt, fire} = 4'h0;
            // Mostly the status word, sometimes any address to prove the decode
            cfg_addr = $urandom % 3 == 0 ? 12'($urandom) : {11'h003, 1'($urandom)};
            rdchk;
            {cfg_wdata, cfg_be} = 18'($urandom);
            cfg_wr_en = 1;
            @(negedge ref_clk);
            cfg_wr_en = 0;
            if (cfg_addr[11:1] == 11'h003 && cfg_be[1]) st &= ~(cfg_wdata & 16'h7100);
        end
        $display("random test done");
        // Reset in mid-run must wipe every sticky flag
        intx_pending = 0;
        srst = 1;
        repeat (2) @(negedge ref_clk);
        srst = 0;
        st = 16'h0000;
        cfg_addr = 12'h007;
        rdchk;
        $display("mid reset test done");
        print_verdict;
    end
endmodule
`default_nettype wire
